//--- hdl/mbic_pkg.sv
// Package of register offsets, fields and carriers for the mailbox interrupt control block
package mbic_pkg;

  localparam int          MBIC_ADDR_W     = 8;
  localparam int          MBIC_NUM_MB     = 16;
  localparam int          MBIC_NUM_DSP    = 3;

  // Register offsets
  localparam logic [7:0]  MBIC_OFS_H2D_EN  = 8'h40;
  localparam logic [7:0]  MBIC_OFS_LSTAT   = 8'h76;
  localparam logic [7:0]  MBIC_OFS_LMASK   = 8'h77;
  localparam logic [7:0]  MBIC_OFS_HWR_EN  = 8'hD0;
  localparam logic [7:0]  MBIC_OFS_HRD_EN  = 8'hD2;
  localparam logic [7:0]  MBIC_OFS_LWR_EN  = 8'hD4;
  localparam logic [7:0]  MBIC_OFS_LRD_EN  = 8'hD6;
  localparam logic [7:0]  MBIC_OFS_WR_STAT = 8'hD8;
  localparam logic [7:0]  MBIC_OFS_RD_STAT = 8'hDA;

  // Local mask and status bit positions
  localparam int          MBIC_BIT_MAILBOX = 7;
  localparam int          MBIC_BIT_PCI_RD  = 6;
  localparam int          MBIC_BIT_PCI_WR  = 5;
  localparam int          MBIC_BIT_PCI_INT = 4;
  localparam int          MBIC_BIT_PERR    = 3;
  localparam int          MBIC_BIT_QWR     = 2;
  localparam int          MBIC_BIT_CH1     = 1;
  localparam int          MBIC_BIT_CH0     = 0;

  // Reset values and enable write mask
  localparam logic [15:0] MBIC_RST_16      = 16'h0000;
  localparam logic [7:0]  MBIC_RST_8       = 8'h00;
  localparam logic [15:0] MBIC_H2D_EN_MASK = 16'h0007;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mbic_req_t;

  // Mailbox access events from both sides, one bit per mailbox
  typedef struct packed {
    logic [15:0] host_wr;
    logic [15:0] host_rd;
    logic [15:0] local_wr;
    logic [15:0] local_rd;
  } mbic_mb_ev_t;

endpackage : mbic_pkg

//--- hdl/mbic_top.sv
// Mailbox interrupt control: enables, sticky status, local and host interrupt outputs
`timescale 1ns/100ps

// Operation
// - Mailbox interrupts reach the local line only while mask bit 7 is set.
// - Read error gated by mask bit 6, write error by mask bit 5.
// - Global PCI interrupt gated by mask bit 4, parity error by bit 3.
// - Queue write by bit 2, channel one by bit 1, channel zero bit 0.
// - Local status bit 7 reads 1 while any mailbox interrupt is pending.
// - Host write/read of mailbox n interrupts local side when enabled.
// - Local write/read of mailbox n interrupts host side when enabled.
// - Mailbox n event sets bit n in write or read status register.
// - Writing 1 clears a mailbox status bit; writing 0 leaves it.
// - Read and write enables are separate registers.
// - DSP line k driven only while enable bit k set; bits 3-15 reserved.
// - Host mailbox summary stays set until both status registers clear.
module mbic_top
  import mbic_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire mbic_req_t   req,
  output logic [15:0]      rdata_q,
  input  wire mbic_mb_ev_t mb_ev,
  input  wire logic [6:0]  src_irq,
  input  wire logic [2:0]  dsp_irq_req,
  output logic             local_irq_q,
  output logic             host_irq_q,
  output logic             host_mb_summary_q,
  output logic [2:0]       dsp_irq_oe_q
);

  // ==========================================================================
  // Input synchronisers for the other interrupt sources
  // ==========================================================================
  logic [6:0] src_s1_q, src_s1_d, src_q, src_d;
  logic [2:0] dreq_s1_q, dreq_s1_d, dreq_q, dreq_d;

  always_comb begin
    src_s1_d  = src_irq;
    src_d     = src_s1_q;
    dreq_s1_d = dsp_irq_req;
    dreq_d    = dreq_s1_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_s1_q  <= 7'h00;
      src_q     <= 7'h00;
      dreq_s1_q <= 3'h0;
      dreq_q    <= 3'h0;
    end else begin
      src_s1_q  <= src_s1_d;
      src_q     <= src_d;
      dreq_s1_q <= dreq_s1_d;
      dreq_q    <= dreq_d;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [15:0] h2d_en_q, h2d_en_d;
  logic [7:0]  lmask_q, lmask_d;
  logic [15:0] hwr_en_q, hwr_en_d, hrd_en_q, hrd_en_d;
  logic [15:0] lwr_en_q, lwr_en_d, lrd_en_q, lrd_en_d;
  logic [15:0] wr_stat_q, wr_stat_d, rd_stat_q, rd_stat_d;
  logic [15:0] wr_set, rd_set, wr_clr, rd_clr;
  logic [15:0] rdata_d;
  logic [7:0]  lstat;
  logic        mb_pend;

  always_comb begin
    h2d_en_d = h2d_en_q;
    lmask_d  = lmask_q;
    hwr_en_d = hwr_en_q;
    hrd_en_d = hrd_en_q;
    lwr_en_d = lwr_en_q;
    lrd_en_d = lrd_en_q;
    if (req.wr) begin
      unique case (req.addr)
        MBIC_OFS_H2D_EN: h2d_en_d = req.wdata & MBIC_H2D_EN_MASK;
        MBIC_OFS_LMASK:  lmask_d  = req.wdata[7:0];
        MBIC_OFS_HWR_EN: hwr_en_d = req.wdata;
        MBIC_OFS_HRD_EN: hrd_en_d = req.wdata;
        MBIC_OFS_LWR_EN: lwr_en_d = req.wdata;
        MBIC_OFS_LRD_EN: lrd_en_d = req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Per-mailbox sticky status
  // ==========================================================================
  logic wr_stat_hit, rd_stat_hit;

  always_comb begin
    wr_stat_hit = req.wr && (req.addr == MBIC_OFS_WR_STAT);
    rd_stat_hit = req.wr && (req.addr == MBIC_OFS_RD_STAT);
  end

  // One slice per mailbox; an event in the cycle of a clear keeps the bit set
  for (genvar mb = 0; mb < MBIC_NUM_MB; mb++) begin : g_mb
    assign wr_set[mb]    = (mb_ev.host_wr[mb] & hwr_en_q[mb])
                         | (mb_ev.local_wr[mb] & lwr_en_q[mb]);
    assign rd_set[mb]    = (mb_ev.host_rd[mb] & hrd_en_q[mb])
                         | (mb_ev.local_rd[mb] & lrd_en_q[mb]);
    assign wr_clr[mb]    = wr_stat_hit & req.wdata[mb];
    assign rd_clr[mb]    = rd_stat_hit & req.wdata[mb];
    assign wr_stat_d[mb] = (wr_stat_q[mb] & ~wr_clr[mb]) | wr_set[mb];
    assign rd_stat_d[mb] = (rd_stat_q[mb] & ~rd_clr[mb]) | rd_set[mb];
  end

  // ==========================================================================
  // Local status: mailbox summary plus synchronised sources
  // ==========================================================================
  always_comb begin
    mb_pend = (|wr_stat_q) | (|rd_stat_q);
    lstat   = {mb_pend, src_q};
  end

  // ==========================================================================
  // Register readback
  // ==========================================================================
  always_comb begin
    rdata_d = MBIC_RST_16;
    if (req.rd) begin
      unique case (req.addr)
        MBIC_OFS_H2D_EN:  rdata_d = h2d_en_q;
        MBIC_OFS_LSTAT:   rdata_d = {8'h00, lstat};
        MBIC_OFS_LMASK:   rdata_d = {8'h00, lmask_q};
        MBIC_OFS_HWR_EN:  rdata_d = hwr_en_q;
        MBIC_OFS_HRD_EN:  rdata_d = hrd_en_q;
        MBIC_OFS_LWR_EN:  rdata_d = lwr_en_q;
        MBIC_OFS_LRD_EN:  rdata_d = lrd_en_q;
        MBIC_OFS_WR_STAT: rdata_d = wr_stat_q;
        MBIC_OFS_RD_STAT: rdata_d = rd_stat_q;
        default:          rdata_d = MBIC_RST_16;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      h2d_en_q  <= MBIC_RST_16;
      lmask_q   <= MBIC_RST_8;
      hwr_en_q  <= MBIC_RST_16;
      hrd_en_q  <= MBIC_RST_16;
      lwr_en_q  <= MBIC_RST_16;
      lrd_en_q  <= MBIC_RST_16;
    end else begin
      h2d_en_q  <= h2d_en_d;
      lmask_q   <= lmask_d;
      hwr_en_q  <= hwr_en_d;
      hrd_en_q  <= hrd_en_d;
      lwr_en_q  <= lwr_en_d;
      lrd_en_q  <= lrd_en_d;
    end
  end

  // Status and readback state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_stat_q <= MBIC_RST_16;
      rd_stat_q <= MBIC_RST_16;
      rdata_q   <= MBIC_RST_16;
    end else begin
      wr_stat_q <= wr_stat_d;
      rd_stat_q <= rd_stat_d;
      rdata_q   <= rdata_d;
    end
  end

  // ==========================================================================
  // Interrupt outputs
  // ==========================================================================
  logic       local_irq_d, host_irq_d, host_sum_d;
  logic [2:0] dsp_oe_d;
  logic [7:0] lgated;
  logic       host_pend;

  // Each local source passes only under its own mask bit
  always_comb begin
    lgated                   = MBIC_RST_8;
    lgated[MBIC_BIT_MAILBOX] = lstat[MBIC_BIT_MAILBOX] & lmask_q[MBIC_BIT_MAILBOX];
    lgated[MBIC_BIT_PCI_RD]  = lstat[MBIC_BIT_PCI_RD] & lmask_q[MBIC_BIT_PCI_RD];
    lgated[MBIC_BIT_PCI_WR]  = lstat[MBIC_BIT_PCI_WR] & lmask_q[MBIC_BIT_PCI_WR];
    lgated[MBIC_BIT_PCI_INT] = lstat[MBIC_BIT_PCI_INT] & lmask_q[MBIC_BIT_PCI_INT];
    lgated[MBIC_BIT_PERR]    = lstat[MBIC_BIT_PERR] & lmask_q[MBIC_BIT_PERR];
    lgated[MBIC_BIT_QWR]     = lstat[MBIC_BIT_QWR] & lmask_q[MBIC_BIT_QWR];
    lgated[MBIC_BIT_CH1]     = lstat[MBIC_BIT_CH1] & lmask_q[MBIC_BIT_CH1];
    lgated[MBIC_BIT_CH0]     = lstat[MBIC_BIT_CH0] & lmask_q[MBIC_BIT_CH0];
  end

  // One gate per DSP line; reserved enable bits never reach a line
  for (genvar ln = 0; ln < MBIC_NUM_DSP; ln++) begin : g_dsp
    assign dsp_oe_d[ln] = dreq_q[ln] & h2d_en_q[ln];
  end

  always_comb begin
    local_irq_d = |lgated;
    // Host side events are status bits whose local-bus enable is set, whichever side set them
    host_pend   = |((wr_stat_q & lwr_en_q) | (rd_stat_q & lrd_en_q));
    host_irq_d  = host_pend;
    host_sum_d  = mb_pend;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      local_irq_q       <= 1'b0;
      host_irq_q        <= 1'b0;
      host_mb_summary_q <= 1'b0;
      dsp_irq_oe_q      <= 3'h0;
    end else begin
      local_irq_q       <= local_irq_d;
      host_irq_q        <= host_irq_d;
      host_mb_summary_q <= host_sum_d;
      dsp_irq_oe_q      <= dsp_oe_d;
    end
  end

endmodule : mbic_top

//--- sim/mbic_checker_properties.sv
// Port checker of the mailbox interrupt control
`timescale 1ns/100ps
module mbic_checker
  import mbic_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire mbic_req_t   req,
  input wire logic [15:0] rdata_q,
  input wire mbic_mb_ev_t mb_ev,
  input wire logic        local_irq_q,
  input wire logic        host_irq_q,
  input wire logic        host_mb_summary_q,
  input wire logic [2:0]  dsp_irq_oe_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Shadows
  logic [7:0] lm_q;
  logic [2:0] en_q;
  logic [15:0] lwe_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lm_q <= 8'h00;
      en_q <= 3'h0;
      lwe_q <= 16'h0000;
    end else if (req.wr) begin
      if (req.addr == MBIC_OFS_LWR_EN) lwe_q <= req.wdata;
      if (req.addr == MBIC_OFS_LMASK) lm_q <= req.wdata[7:0];
      if (req.addr == MBIC_OFS_H2D_EN) en_q <= req.wdata[2:0];
    end
  end
  // ==========
  // Properties
  property p_rsv; req.rd && req.addr == MBIC_OFS_H2D_EN |=> rdata_q[15:3] == 13'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv bits");
  property p_dsp; (dsp_irq_oe_q & ~$past(en_q)) == 3'h0; endproperty
  a_dsp: assert property (p_dsp) else $error("dsp gate");
  property p_ls; req.rd && req.addr == MBIC_OFS_LSTAT |=> rdata_q[7] == host_mb_summary_q; endproperty
  a_ls: assert property (p_ls) else $error("lstat7");
  property p_mb; lm_q == 8'h80 |=> local_irq_q == host_mb_summary_q; endproperty
  a_mb: assert property (p_mb) else $error("mb mask");
  property p_off; lm_q == 8'h00 |=> !local_irq_q; endproperty
  a_off: assert property (p_off) else $error("mask off");
  property p_up; $rose(host_mb_summary_q) |-> $past(|mb_ev, 2); endproperty
  a_up: assert property (p_up) else $error("sum rise");
  property p_dn; $fell(host_mb_summary_q) |-> $past(req.wr, 2); endproperty
  a_dn: assert property (p_dn) else $error("sum fall");
  property p_hi;
    |(mb_ev.local_wr & lwe_q) && !(req.wr && req.addr == MBIC_OFS_LWR_EN) |-> ##2 host_irq_q;
  endproperty
  a_hi: assert property (p_hi) else $error("host irq");
  c_li: cover property ($rose(local_irq_q));
  c_hi: cover property ($rose(host_irq_q));
  c_dn: cover property ($fell(host_mb_summary_q));
endmodule : mbic_checker
bind mbic_top mbic_checker mbic_checker_inst (.core_clk(core_clk), .arst_n(arst_n),
  .req(req), .rdata_q(rdata_q), .mb_ev(mb_ev), .local_irq_q(local_irq_q),
  .host_irq_q(host_irq_q), .host_mb_summary_q(host_mb_summary_q), .dsp_irq_oe_q(dsp_irq_oe_q));

//--- sim/mbic_partner.sv
// Host and local master issuing mailbox accesses
`timescale 1ns/100ps
module mbic_partner
  import mbic_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  input  wire logic  dsp_post,
  output mbic_mb_ev_t mb_ev
);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) mb_ev <= '0;
    else if (dsp_post || $urandom_range(15) == 0) mb_ev <= {32'h0, 16'h000F, 16'h0};
    else mb_ev <= {$urandom & $urandom & $urandom, $urandom & $urandom & $urandom};
  end
endmodule : mbic_partner

//--- sim/mbic_tb_top.sv
// Random bench with reference model of the mailbox interrupt control
`timescale 1ns/100ps
module mbic_tb_top;
  import mbic_pkg::*;
  logic        core_clk, arst_n, local_irq_q, host_irq_q, host_mb_summary_q;
  mbic_req_t   req = '0;
  mbic_mb_ev_t mb_ev;
  logic [15:0] rdata_q, e_rd, h2d = 0, hwe = 0, hre = 0, lwe = 0, lre = 0, wst = 0, rst = 0;
  logic [7:0]  lm = 0;
  logic [6:0]  src_irq = 0, s1 = 0, s2 = 0;
  logic [2:0]  dsp_irq_req = 0, dsp_irq_oe_q, d1 = 0, d2 = 0, e_oe;
  logic        e_li, e_hi, e_sum;
  logic        dsp_post = 1'b0;
  int          fails, compares, cyc;
  logic [7:0]  ofs [10] = '{8'h40, 8'h76, 8'h77, 8'hD0, 8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hDA, 8'h10};
  mbic_top mbic_top_inst (.core_clk(core_clk), .arst_n(arst_n), .req(req), .rdata_q(rdata_q),
    .mb_ev(mb_ev), .src_irq(src_irq), .dsp_irq_req(dsp_irq_req), .local_irq_q(local_irq_q),
    .host_irq_q(host_irq_q), .host_mb_summary_q(host_mb_summary_q), .dsp_irq_oe_q(dsp_irq_oe_q));
  mbic_partner mbic_partner_inst (.core_clk(core_clk), .arst_n(arst_n), .dsp_post(dsp_post),
    .mb_ev(mb_ev));
  // ==========
  // Model
  function automatic logic [15:0] rd(logic [7:0] a);
    case (a)
      MBIC_OFS_H2D_EN: return h2d;
      MBIC_OFS_LSTAT: return {8'h00, |(wst | rst), s2};
      MBIC_OFS_LMASK: return {8'h00, lm};
      MBIC_OFS_HWR_EN: return hwe;
      MBIC_OFS_HRD_EN: return hre;
      MBIC_OFS_LWR_EN: return lwe;
      MBIC_OFS_LRD_EN: return lre;
      MBIC_OFS_WR_STAT: return wst;
      MBIC_OFS_RD_STAT: return rst;
      default: return 16'h0000;
    endcase
  endfunction : rd
  task automatic step;
    e_rd = req.rd ? rd(req.addr) : 16'h0000;
    e_li = |({|(wst | rst), s2} & lm);
    e_hi = |((wst & lwe) | (rst & lre));
    e_sum = |(wst | rst);
    e_oe = d2 & h2d[2:0];
    s2 = s1;
    s1 = src_irq;
    d2 = d1;
    d1 = dsp_irq_req;
    if (req.wr && req.addr == MBIC_OFS_WR_STAT) wst = wst & ~req.wdata;
    if (req.wr && req.addr == MBIC_OFS_RD_STAT) rst = rst & ~req.wdata;
    wst = wst | (mb_ev.host_wr & hwe) | (mb_ev.local_wr & lwe);
    rst = rst | (mb_ev.host_rd & hre) | (mb_ev.local_rd & lre);
    if (req.wr) case (req.addr)
      MBIC_OFS_H2D_EN: h2d = req.wdata & MBIC_H2D_EN_MASK;
      MBIC_OFS_LMASK: lm = req.wdata[7:0];
      MBIC_OFS_HWR_EN: hwe = req.wdata;
      MBIC_OFS_HRD_EN: hre = req.wdata;
      MBIC_OFS_LWR_EN: lwe = req.wdata;
      MBIC_OFS_LRD_EN: lre = req.wdata;
      default: ;
    endcase
  endtask : step
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    compares++;
    if (e !== s) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic tick(logic w, logic r, logic [7:0] a, logic [15:0] d);
    @(posedge core_clk);
    step();
    req.wr <= w;
    req.rd <= r;
    req.addr <= a;
    req.wdata <= d;
    if ($urandom_range(7) == 0) src_irq <= 7'($urandom);
    if ($urandom_range(7) == 0) dsp_irq_req <= 3'($urandom);
    #1;
    chk("rdata", e_rd, rdata_q);
    chk("irq", {10'h0, e_li, e_hi, e_sum, e_oe},
      {10'h0, local_irq_q, host_irq_q, host_mb_summary_q, dsp_irq_oe_q});
  endtask : tick
  // ==========
  // Clock, timeout, stimulus
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'hAB61B64D));
    arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    tick(1'b1, 1'b0, MBIC_OFS_LMASK, 16'h0080);
    tick(1'b1, 1'b0, MBIC_OFS_LWR_EN, 16'h0001);
    dsp_post <= 1'b1;
    tick(1'b0, 1'b0, 8'h00, 16'h0000);
    dsp_post <= 1'b0;
    repeat (4) tick(1'b0, 1'b0, 8'h00, 16'h0000);
    chk("host_irq_q", 16'h0001, {15'h0000, host_irq_q});
    tick(1'b0, 1'b1, MBIC_OFS_WR_STAT, 16'h0000);
    tick(1'b1, 1'b0, MBIC_OFS_WR_STAT, 16'h0001);
    repeat (3000) tick($urandom_range(3) == 0, 1'($urandom_range(1)), ofs[$urandom_range(9)],
      16'($urandom));
    final_report();
  end
endmodule : mbic_tb_top
